// ==== core/dcf_fifo_flags.sv ====
`timescale 1ns/10ps

// ==========================================================
// Prefetch buffer between storage and read port
module dcf_buf #(
  parameter int W = 9,
  parameter int D = 4
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);
  localparam int PW = (D > 1) ? $clog2(D) : 1;
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } dcf_buf_st_t;
  dcf_buf_st_t s_q, s_d;
  logic push, pop;

  function automatic logic [PW-1:0] nextPtr(input logic [PW-1:0] p);
    nextPtr = (p == PW'(D - 1)) ? '0 : PW'(p + 1'b1);
  endfunction : nextPtr

  assign inReady = (s_q.cnt != (PW + 1)'(D));
  assign outValid = (s_q.cnt != '0);
  assign outData = s_q.mem[s_q.rp];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = inData;
      s_d.wp = nextPtr(s_q.wp);
    end
    if (pop) begin
      s_d.rp = nextPtr(s_q.rp);
    end
    s_d.cnt = (PW + 1)'(s_q.cnt + push - pop);
    if (!nrst) begin
      s_d.wp = '0;
      s_d.rp = '0;
      s_d.cnt = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    s_q <= s_d;
  end
endmodule : dcf_buf

// ==========================================================
// FIFO core with reset strap, flags and offsets
module dcf_fifo_flags #(
  parameter int DEPTH = dcf_pkg::DEPTH_DEF
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic wrTick,
  input wire logic wrEn1N,
  input wire logic wr_en2_or_offset_load,
  input wire logic [dcf_pkg::DATA_W-1:0] wrData,
  input wire logic rdTick,
  input wire logic rdEnN,
  input wire logic outEnN,
  output logic [dcf_pkg::DATA_W-1:0] rdData,
  output logic rdDataOe,
  output logic empty_n,
  output logic full_n,
  output logic almost_empty_n,
  output logic almost_full_n,
  output logic loadMode
);
  localparam int AW = $clog2(DEPTH);
  localparam int OW = AW + 1;
  localparam int DW = dcf_pkg::DATA_W;
  localparam logic [OW-1:0] DEPTH_W = OW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [OW-1:0] stCnt;
    logic [OW-1:0] occ;
    logic emptyN;
    logic fullN;
    logic aeN;
    logic afN;
    logic [DW-1:0] rdData;
    logic oe;
    logic [OW-1:0] offE;
    logic [OW-1:0] offF;
    dcf_pkg::dcf_ld_t ldSel;
    logic mode;
    logic syncA;
    logic syncB;
  } dcf_st_t;
  dcf_st_t s_q, s_d;

  logic pinHigh, wrOk, ldOk, rdOk, xfer, bufInReady, bufOutValid;
  logic [DW-1:0] bufOutData;
  logic [OW-1:0] occAfterRd, occAfterWr;

  function automatic logic [AW-1:0] incPtr(input logic [AW-1:0] p);
    incPtr = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction : incPtr

  // ==========================================================
  // Port decode
  assign pinHigh = s_q.syncB;
  assign wrOk = wrTick & ~wrEn1N & pinHigh & s_q.fullN;
  assign ldOk = wrTick & ~wrEn1N & ~pinHigh & s_q.mode;
  assign rdOk = rdTick & ~rdEnN & s_q.emptyN & bufOutValid;
  assign xfer = (s_q.stCnt != '0) & bufInReady;
  // Flags see the registered count plus their own side's transfer, so the other side's edge in the same cycle waits one more edge
  assign occAfterRd = OW'(s_q.occ - rdOk);
  assign occAfterWr = OW'(s_q.occ + wrOk);

  dcf_buf #(.W(DW), .D(dcf_pkg::BUF_DEPTH)) u_buf (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .inValid(xfer),
    .inReady(bufInReady),
    .inData(s_q.mem[s_q.rp]),
    .outValid(bufOutValid),
    .outReady(rdOk),
    .outData(bufOutData)
  );

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.syncA = wr_en2_or_offset_load;
    s_d.syncB = s_q.syncA;
    s_d.oe = ~outEnN;
    if (wrOk) begin
      s_d.mem[s_q.wp] = wrData;
      s_d.wp = incPtr(s_q.wp);
    end
    if (xfer) begin
      s_d.rp = incPtr(s_q.rp);
    end
    s_d.stCnt = OW'(s_q.stCnt + wrOk - xfer);
    s_d.occ = OW'(s_q.occ + wrOk - rdOk);
    if (ldOk) begin
      if (s_q.ldSel == dcf_pkg::DCF_LD_EMPTY) begin
        s_d.offE = OW'(wrData);
        s_d.ldSel = dcf_pkg::DCF_LD_FULL;
      end else begin
        s_d.offF = OW'(wrData);
        s_d.ldSel = dcf_pkg::DCF_LD_EMPTY;
      end
    end
    if (rdOk) begin
      s_d.rdData = bufOutData;
    end
    if (rdTick) begin
      s_d.emptyN = (occAfterRd != '0);
      s_d.aeN = (occAfterRd >= s_q.offE);
    end
    if (wrTick) begin
      s_d.fullN = (occAfterWr != DEPTH_W);
      s_d.afN = (occAfterWr <= OW'(DEPTH_W - s_q.offF));
    end
    // Edges keep arriving during reset and are simply overridden here
    if (!nrst) begin
      s_d.wp = '0;
      s_d.rp = '0;
      s_d.stCnt = '0;
      s_d.occ = '0;
      s_d.emptyN = dcf_pkg::RST_EMPTY_N;
      s_d.fullN = dcf_pkg::RST_FULL_N;
      s_d.aeN = dcf_pkg::RST_AEMPTY_N;
      s_d.afN = dcf_pkg::RST_AFULL_N;
      s_d.rdData = '0;
      s_d.offE = OW'(dcf_pkg::OFFS_EMPTY_RST);
      s_d.offF = OW'(dcf_pkg::OFFS_FULL_RST);
      s_d.ldSel = dcf_pkg::DCF_LD_EMPTY;
      // Pin level sampled two edges before the last reset edge, through syncA and syncB, decides the mode
      s_d.mode = ~s_q.syncB;
    end
  end

  always_ff @(posedge ref_clk) begin
    s_q <= s_d;
  end

  assign rdData = s_q.rdData;
  assign rdDataOe = s_q.oe;
  assign empty_n = s_q.emptyN;
  assign full_n = s_q.fullN;
  assign almost_empty_n = s_q.aeN;
  assign almost_full_n = s_q.afN;
  assign loadMode = s_q.mode;

  // ==========================================================
  // Checks
  chk_reset_flags: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(nrst) |-> (!empty_n && full_n && !almost_empty_n && almost_full_n && s_q.occ == '0))
    else $error("flags wrong after reset");
  chk_data_low: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(nrst) |-> (rdData == '0))
    else $error("data not low after reset");
  chk_oe_follow: assert property (@(posedge ref_clk) disable iff (!nrst)
    outEnN ##1 outEnN |-> !rdDataOe)
    else $error("output driven while disabled");
  chk_mode_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    $past(nrst) |-> $stable(loadMode))
    else $error("pin mode changed outside reset");
  chk_full_block: assert property (@(posedge ref_clk) disable iff (!nrst)
    (wrTick && !full_n) |=> $stable(s_q.wp))
    else $error("write taken while full");
  chk_empty_block: assert property (@(posedge ref_clk) disable iff (!nrst)
    (rdTick && !empty_n) |=> ($stable(rdData) && s_q.occ >= $past(s_q.occ)))
    else $error("read taken while empty");
  chk_first_word: assert property (@(posedge ref_clk) disable iff (!nrst)
    rdOk |=> (rdData == $past(bufOutData)))
    else $error("read word not presented");
  chk_empty_skew: assert property (@(posedge ref_clk) disable iff (!nrst)
    (rdTick && s_q.occ == '0) |=> !empty_n)
    else $error("empty cleared by same-cycle write");
  chk_empty_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
    (rdTick && s_q.occ > OW'(1)) |=> empty_n)
    else $error("empty still set with words stored");
  chk_ae_level: assert property (@(posedge ref_clk) disable iff (!nrst)
    (rdTick && s_q.occ == s_q.offE && rdOk) |=> !almost_empty_n)
    else $error("almost empty not asserted at n-1");
  chk_af_level: assert property (@(posedge ref_clk) disable iff (!nrst)
    (wrTick && wrOk && occAfterWr == OW'(DEPTH_W - s_q.offF + 1'b1)) |=> !almost_full_n)
    else $error("almost full not asserted at m-1 free");
endmodule : dcf_fifo_flags

// ==== core/dcf_pkg.sv ====
package dcf_pkg;
  // ==========================================================
  // Geometry
  localparam int DATA_W = 9;
  localparam int DEPTH_DEF = 64;
  localparam int BUF_DEPTH = 4;
  // ==========================================================
  // Values after reset
  localparam int OFFS_EMPTY_RST = 7;
  localparam int OFFS_FULL_RST = 7;
  localparam logic RST_EMPTY_N = 1'h0;
  localparam logic RST_FULL_N = 1'h1;
  localparam logic RST_AEMPTY_N = 1'h0;
  localparam logic RST_AFULL_N = 1'h1;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int EDGE_SKEW_MIN_BASIC_NS = 6;
  localparam int EDGE_SKEW_MIN_ALMOST_NS = 15;
  localparam int EDGE_SKEW_MIN_BASIC_CYC =
    (EDGE_SKEW_MIN_BASIC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EDGE_SKEW_MIN_ALMOST_CYC =
    (EDGE_SKEW_MIN_ALMOST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ==========================================================
  // Offset load sequence
  typedef enum logic [0:0] {
    DCF_LD_EMPTY = 1'h0,
    DCF_LD_FULL = 1'h1
  } dcf_ld_t;
endpackage : dcf_pkg

// ==== tb/dcf_partner.sv ====
`timescale 1ns/10ps
// ==========
// Writer and reader edges
module dcf_partner (
  input wire logic ref_clk,
  input wire logic slow,
  output logic wrTick,
  output logic rdTick
);
  logic ph = 1'h0;
  initial begin
    wrTick = 1'h0;
    rdTick = 1'h0;
  end
  // Edges never stop, reset included; slow mode alternates them so skew is never too short
  always @(posedge ref_clk) begin
    ph <= ~ph;
    wrTick <= slow ? ph : 1'h1;
    rdTick <= slow ? ~ph : 1'h1;
  end
endmodule : dcf_partner

// ==== tb/dcf_fifo_flags_tb.sv ====
`timescale 1ns/10ps
// ==========
// Bench
module dcf_fifo_flags_tb;
  logic ref_clk = 1'h0, nrst = 1'h0, wrEn1N = 1'h1, pin = 1'h1, rdEnN = 1'h1, outEnN = 1'h0, slow = 1'h0;
  logic [8:0] wrData = 9'h000;
  logic wrTick, rdTick, rdDataOe, empty_n, full_n, almost_empty_n, almost_full_n, loadMode;
  localparam int DEPTH = dcf_pkg::DEPTH_DEF;
  logic tk1 = 1'h0, ldSel = 1'h0;
  logic [8:0] rdData;
  logic [8:0] q[$];
  logic [1:0] fq[$], eq[$], fn, en;
  int errors = 0, n_tests = 0, occ = 0, i, offE = 0, offF = 0;
  initial forever #25 ref_clk = ~ref_clk;
  dcf_partner PM (.ref_clk(ref_clk), .slow(slow), .wrTick(wrTick), .rdTick(rdTick));
  dcf_fifo_flags #(.DEPTH(DEPTH)) DUT (.ref_clk(ref_clk), .nrst(nrst), .wrTick(wrTick), .wrEn1N(wrEn1N),
    .wr_en2_or_offset_load(pin), .wrData(wrData), .rdTick(rdTick), .rdEnN(rdEnN), .outEnN(outEnN),
    .rdData(rdData), .rdDataOe(rdDataOe), .empty_n(empty_n), .full_n(full_n),
    .almost_empty_n(almost_empty_n), .almost_full_n(almost_full_n), .loadMode(loadMode));
  task end_of_test;
    if (errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  task chkWord(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkWord
  task chkBit(input logic got, input logic exp);
    chkWord({8'h00, got}, {8'h00, exp});
  endtask : chkBit
  // Bounded wait for the partner's next edge; a lost edge ends the run as failed after 8 clocks
  task tick(input logic w);
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while ((w ? wrTick : rdTick) !== 1'h1 && k < 8);
    if ((w ? wrTick : rdTick) !== 1'h1) begin
      errors++;
      end_of_test;
    end
  endtask : tick
  // Requests change only at a rising edge; a caller parked at a falling edge waits for one
  task align;
    if (ref_clk !== 1'h1) @(posedge ref_clk);
  endtask : align
  // Enables stay low after a transfer so bursts run back to back; idle drops them
  task wr(input logic [8:0] d);
    align;
    wrEn1N <= 1'h0;
    wrData <= d;
    tick(1'h1);
    if (full_n === 1'h1 && pin === 1'h1) begin
      q.push_back(d);
      occ++;
    end
    // Flags after this edge still use the offsets from before a load
    fq.push_back({occ != DEPTH, occ <= DEPTH - offF});
    if (loadMode === 1'h1 && pin === 1'h0) begin
      if (ldSel) offF = int'(d);
      else offE = int'(d);
      ldSel = ~ldSel;
    end
  endtask : wr
  task rd;
    align;
    rdEnN <= 1'h0;
    tick(1'h0);
    if (empty_n === 1'h1) occ--;
    eq.push_back({occ != 0, occ >= offE});
  endtask : rd
  // Ends at a falling edge so that flags are read settled
  task idle;
    wrEn1N <= 1'h1;
    rdEnN <= 1'h1;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : idle
  task rst(input logic p);
    align;
    nrst <= 1'h0;
    pin <= p;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'h1;
    q.delete();
    occ = 0;
    offE = dcf_pkg::OFFS_EMPTY_RST;
    offF = dcf_pkg::OFFS_FULL_RST;
    ldSel = 1'h0;
    @(negedge ref_clk);
    chkBit(empty_n, 1'h0);
    chkBit(almost_empty_n, 1'h0);
    chkBit(full_n, 1'h1);
    chkBit(almost_full_n, 1'h1);
    chkWord(rdData, 9'h000);
    chkBit(rdDataOe, 1'h1);
    chkBit(loadMode, ~p);
  endtask : rst
  // ==========
  // Monitor: read data stands from the edge that takes the read; flags are noted per tick
  always @(posedge ref_clk) begin
    tk1 <= nrst && rdTick && !rdEnN && empty_n;
  end
  always @(negedge ref_clk) begin
    if (tk1 === 1'h1) chkWord(rdData, q.size() > 0 ? q.pop_front() : 9'h1FF);
    if (fq.size() > 0) begin
      fn = fq.pop_front();
      chkBit(full_n, fn[1]);
      chkBit(almost_full_n, fn[0]);
    end
    if (eq.size() > 0) begin
      en = eq.pop_front();
      chkBit(empty_n, en[1]);
      chkBit(almost_empty_n, en[0]);
    end
  end
  initial begin
    void'($urandom(32'hF440));
    rst(1'h1);
    align;
    outEnN <= 1'h1;
    @(negedge ref_clk);
    @(negedge ref_clk);
    chkBit(rdDataOe, 1'h0);
    align;
    outEnN <= 1'h0;
    rd;
    idle;
    chkBit(empty_n, 1'h0);
    align;
    slow <= 1'h1;
    wr(9'($urandom()));
    idle;
    for (i = 0; i < 4 && empty_n !== 1'h1; i++) @(negedge ref_clk);
    chkBit(empty_n, 1'h1);
    rd;
    idle;
    align;
    slow <= 1'h0;
    for (i = 0; i < 65; i++) wr(9'($urandom()));
    idle;
    for (i = 0; i < 65; i++) rd;
    idle;
    align;
    pin <= 1'h0;
    idle;
    wr(9'h0AA);
    idle;
    chkBit(empty_n, 1'h0);
    rst(1'h0);
    wr(9'h002);
    wr(9'h003);
    idle;
    align;
    pin <= 1'h1;
    idle;
    wr(9'($urandom()));
    wr(9'($urandom()));
    idle;
    chkBit(almost_empty_n, 1'h1);
    rd;
    rd;
    idle;
    chkBit(empty_n, 1'h0);
    // Loaded full offset: fill to just past the threshold
    for (i = 0; i < 62; i++) wr(9'($urandom()));
    idle;
    chkBit(almost_full_n, 1'h0);
    end_of_test;
  end
endmodule : dcf_fifo_flags_tb
